// ### test_vector_fp_special_value_unit.sv
/*
  Self-checking bench with a per-lane model.
  Assumes the issue model drives all inputs but clock and reset.
*/
`timescale 1ns/1ps
module test_vector_fp_special_value_unit;
  import vfs_pkg::*;
  logic clk, rst, opValid, flushToZeroMode, satClear, resultValid, saturationFlag, satExp;
  vfs_op_type opCode;
  logic [4:0] scaleImmediate;
  logic [127:0] firstSourceOperand, secondSourceOperand, thirdSourceOperand, coreResult;
  logic [127:0] resultData, flushedFirst, flushedSecond, flushedThird, lastX;
  logic [3:0] intermSign, intermZero, intermInf;
  logic [39:0] intermExp;
  logic [103:0] intermSig;
  logic [31:0] va[4], vb[4], vc[4], cr[4];
  logic [25:0] gs[4];
  logic sg[4];
  int ex[4];
  int errors, checks_done;
  vfs_special_value_unit vfs_special_value_unit_inst (.clk, .rst, .opValid, .opCode,
    .flushToZeroMode, .scaleImmediate, .firstSourceOperand, .secondSourceOperand,
    .thirdSourceOperand, .coreResult, .intermSign, .intermExp, .intermSig, .intermZero,
    .intermInf, .satClear, .resultValid, .resultData, .flushedFirst, .flushedSecond,
    .flushedThird, .saturationFlag);
  vfs_issue_model vfs_issue_model_inst (.opCode, .opValid, .flushToZeroMode, .satClear,
    .scaleImmediate, .firstSourceOperand, .secondSourceOperand, .thirdSourceOperand,
    .coreResult, .intermSign, .intermExp, .intermSig, .intermZero, .intermInf);
  // ----------------------------------------------------------------
  // Lane model
  // ----------------------------------------------------------------
  function automatic bit isNan(logic [31:0] x);
    return x[30:23] == 8'hFF && x[22:0] != 23'h0;
  endfunction
  function automatic logic [31:0] flz(logic [31:0] x, logic f);
    return (f && x[30:23] == 8'h00) ? {x[31], 31'h0} : x;
  endfunction
  function automatic logic [31:0] pack(logic s, int e, logic [25:0] g, logic f);
    if (e > 127) return {s, 31'h7F800000};
    if (e < -126) return f ? {s, 31'h0} : {s, 8'h00, 23'(g[25:2] >> (-126 - e))};
    return {s, 8'(e + 127), g[24:2]};
  endfunction
  // Flushing comes first, so a flushed denormal acts as a zero.
  function automatic logic [31:0] model(vfs_op_type o, logic [31:0] a0, b0, c0, r0, logic s,
    int e, logic [25:0] g, logic f, int sc, output bit saturation_flag);
    logic [31:0] a, b, c;
    int ue;
    bit ov, bad;
    {a, b, c} = {flz(a0, f), flz(b0, f), flz(c0, f)};
    ue = int'(a[30:23]) - 127 + sc;
    saturation_flag = 0;
    case (o)
      OP_CONV_U, OP_CONV_S:
      begin
        if (isNan(a)) return 32'h00000000;
        if (o == OP_CONV_U) ov = a[30:23] != 0 && (a[31] ? ue >= 0 : ue >= 32);
        else ov = a[30:23] != 0 && (ue > 31 || (ue == 31 && !(a[31] && a[22:0] == 0)));
        saturation_flag = ov;
        if (!ov) return r0;
        if (o == OP_CONV_U) return a[31] ? 32'h00000000 : 32'hFFFFFFFF;
        return a[31] ? 32'h80000000 : 32'h7FFFFFFF;
      end
      OP_CMP_BOUNDS: return (isNan(a) || isNan(b)) ? 32'hC0000000 : r0;
      OP_CMP_OTHER: return (isNan(a) || isNan(b)) ? 32'h00000000 : r0;
      OP_RECIP, OP_RSQRT, OP_LOG2:
      begin
        if (isNan(a)) return a | 32'h00400000;
        if (a[30:0] == 0) return (o == OP_LOG2) ? 32'hFF800000 : {a[31], 31'h7F800000};
        return (o != OP_RECIP && a[31]) ? 32'h7FC00000 : r0;
      end
      default:
      begin
        if (isNan(a)) return a | 32'h00400000;
        if (isNan(b)) return b | 32'h00400000;
        if (o == OP_MADD && isNan(c)) return c | 32'h00400000;
        bad = a[30:0] == 31'h7F800000 && (o == OP_MUL ? b[30:0] == 0
          : b[30:0] == 31'h7F800000 && (a[31] ^ b[31]) == (o == OP_ADD));
        return bad ? 32'h7FC00000 : pack(s, e, g, f);
      end
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Driving and checking
  // ----------------------------------------------------------------
  task automatic chk(bit ok, string what);
    checks_done++;
    if (!ok)
    begin
      errors++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  // Small normal operands, so nothing saturates or flushes by chance.
  task automatic fill();
    logic [31:0] r;
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      va[i] = {r[31], 4'h6, r[26:0]};
      vb[i] = {r[0], 4'h6, r[27:1]};
      vc[i] = {r[1], 4'h6, r[28:2]};
      cr[i] = $urandom;
      r = $urandom;
      sg[i] = r[31];
      ex[i] = int'(r[27:24]) - 8;
      gs[i] = {1'b1, r[22:0], 2'b00};
    end
  endtask
  task automatic run(vfs_op_type o, int sc, logic f);
    logic [127:0] a, b, c, r;
    logic [383:0] fl;
    logic [39:0] e;
    logic [103:0] g;
    logic [3:0] s;
    bit st;
    for (int i = 0; i < 4; i++)
    begin
      if (o <= OP_MADD) cr[i] = pack(sg[i], ex[i], gs[i], f);
      lastX[32*i+:32] = model(o, va[i], vb[i], vc[i], cr[i], sg[i], ex[i], gs[i], f, sc, st);
      satExp = satExp | st;
      {a[32*i+:32], b[32*i+:32], c[32*i+:32], r[32*i+:32]} = {va[i], vb[i], vc[i], cr[i]};
      {fl[256+32*i+:32], fl[128+32*i+:32], fl[32*i+:32]} = {flz(vc[i], f), flz(vb[i], f),
        flz(va[i], f)};
      {s[i], e[10*i+:10], g[26*i+:26]} = {sg[i], 10'(ex[i]), gs[i]};
    end
    vfs_issue_model_inst.send(o, f, 5'(sc), a, b, c, r, s, e, g);
    @(negedge clk);
    chk(resultValid === 1'b1 && resultData === lastX, "result");
    chk({flushedThird, flushedSecond, flushedFirst} === fl, "flushed sources");
    chk(saturationFlag === satExp, "saturation");
  endtask
  task automatic gap();
    vfs_issue_model_inst.idle();
    @(negedge clk);
    chk(resultValid === 1'b0 && resultData === lastX, "idle cycle");
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Operations run back to back unless a gap is asked.
  initial
  begin
    rst = 1'b1;
    {errors, checks_done, satExp, lastX} = '0;
    void'($urandom(91));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    fill();
    {va[0], vb[1], vc[2], va[3], vb[3]} = {32'h7F800001, 32'hFFC00123, 32'h7FA00000,
      32'h7F800000, 32'hFF812345};
    run(OP_MADD, 0, 1'b0);
    $display("NaN selection test done");
    for (int f = 0; f < 2; f++)
      for (int k = 0; k < 3; k++)
      begin
        fill();
        va[0] = 32'h7F800000;
        vb[0] = (k == 2) ? 32'h0 : {k == 0, 31'h7F800000};
        {ex[1], ex[2], gs[2], va[3]} = {128, -127, 26'h2000000, 32'h80000123};
        run(vfs_op_type'(k), 0, f[0]);
      end
    gap();
    $display("Arithmetic exception test done");
    for (int f = 0; f < 2; f++)
      for (int k = 4; k < 7; k++)
      begin
        {va[0], va[1]} = {32'h0, f ? 32'h80000001 : 32'h80000000};
        {va[2], va[3]} = {32'hBFC00000, 32'h7F800010};
        run(vfs_op_type'(k), 0, f[0]);
      end
    $display("Estimate test done");
    for (int k = 9; k < 11; k++)
    begin
      fill();
      {va[0], vb[1]} = {32'h7FC00000, 32'hFF800001};
      run(vfs_op_type'(k), 0, 1'b0);
    end
    gap();
    $display("Compare test done");
    fill();
    va[0] = 32'hFFFFFFFF;
    run(OP_CONV_U, 1, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      fill();
      {va[0], va[1], va[2]} = {32'h7F800001, 32'h7F800000, 32'hFF800000};
      va[3] = k[1] ? 32'h4F000000 : 32'hCF000000;
      run(k[0] ? OP_CONV_S : OP_CONV_U, k[1], 1'b0);
    end
    gap();
    vfs_issue_model_inst.setClear(1'b1);
    @(negedge clk);
    vfs_issue_model_inst.setClear(1'b0);
    satExp = 1'b0;
    chk(saturationFlag === 1'b0, "saturation clear");
    $display("Conversion test done");
    conclude();
  end
endmodule // test_vector_fp_special_value_unit

// ### vfs_classify.sv
/*
  Classifies one element and flushes it when asked.
  Assumes inputs come from same-clock logic.
*/
`timescale 1ns/1ps
module vfs_classify
(
  input wire logic [vfs_pkg::ELEM_W-1:0] element,
  input wire logic flushToZeroMode,
  output logic [vfs_pkg::ELEM_W-1:0] flushedElement,
  output logic [vfs_pkg::ELEM_W-1:0] quietedElement,
  output logic isNan,
  output logic isInf,
  output logic isZero
);
  import vfs_pkg::*;

  logic [7:0] expField;
  logic [22:0] fracField;
  logic isDenorm;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // The sign bit takes no part in any of these tests.
  assign expField = element[EXP_MSB:EXP_LSB];
  assign fracField = element[FRAC_MSB:0];
  assign isNan = (expField == EXP_ALL_ONES) && (fracField != FRAC_ZERO);
  assign isInf = (expField == EXP_ALL_ONES) && (fracField == FRAC_ZERO);
  assign isDenorm = (expField == EXP_ZERO) && (fracField != FRAC_ZERO);

  // A denormal counts as zero only when flushing is on.
  assign isZero = (expField == EXP_ZERO) && (!isDenorm || flushToZeroMode);

  // Flushed copy keeps the sign so the zero is correctly signed.
  assign flushedElement = (isDenorm && flushToZeroMode) ?
    {element[SIGN_POS], ZERO_MAG} : element;

  // Setting the quiet bit leaves a quiet NaN bit for bit unchanged.
  assign quietedElement = {element[SIGN_POS:EXP_LSB], fracField | QUIET_MASK};

endmodule // vfs_classify

// ### vfs_issue_model.sv
/*
  Issue-side partner model driving the unit's inputs.
  Assumes tasks are called at a falling edge.
*/
`timescale 1ns/1ps
module vfs_issue_model
(
  output vfs_pkg::vfs_op_type opCode,
  output logic opValid,
  output logic flushToZeroMode,
  output logic satClear,
  output logic [4:0] scaleImmediate,
  output logic [127:0] firstSourceOperand,
  output logic [127:0] secondSourceOperand,
  output logic [127:0] thirdSourceOperand,
  output logic [127:0] coreResult,
  output logic [3:0] intermSign,
  output logic [39:0] intermExp,
  output logic [103:0] intermSig,
  output logic [3:0] intermZero,
  output logic [3:0] intermInf
);
  import vfs_pkg::*;
  // ----------------------------------------------------------------
  // Drive tasks
  // ----------------------------------------------------------------
  // Idle at time zero; the exact zero and infinity hints are never raised.
  initial
  begin
    {opValid, flushToZeroMode, satClear, scaleImmediate} = '0;
    {intermSign, intermZero, intermInf, intermExp, intermSig} = '0;
    {firstSourceOperand, secondSourceOperand, thirdSourceOperand, coreResult} = '0;
    opCode = OP_ADD;
  end
  // One operation; the caller holds it through the sampling edge.
  task automatic send(vfs_op_type o, logic f, logic [4:0] sc, logic [127:0] a, b, c, r,
    logic [3:0] s, logic [39:0] e, logic [103:0] g);
    opValid = 1'b1;
    opCode = o;
    {flushToZeroMode, scaleImmediate} = {f, sc};
    {firstSourceOperand, secondSourceOperand, thirdSourceOperand, coreResult} = {a, b, c, r};
    {intermSign, intermExp, intermSig} = {s, e, g};
  endtask
  // The first source and core result lines show inverted data while idle, so stale values are never read.
  task automatic idle();
    opValid = 1'b0;
    firstSourceOperand = ~firstSourceOperand;
    coreResult = ~coreResult;
  endtask
  task automatic setClear(logic v);
    satClear = v;
  endtask
endmodule // vfs_issue_model

// ### vfs_pkg.sv
/*
  Constants and types of the special-value unit.
  Assumes four single-precision elements per vector.
*/
package vfs_pkg;

  // ----------------------------------------------------------------
  // Element layout
  // ----------------------------------------------------------------
  localparam int LANES = 4;
  localparam int ELEM_W = 32;
  localparam int VEC_W = 128;
  localparam int SIGN_POS = 31;
  localparam int EXP_MSB = 30;
  localparam int EXP_LSB = 23;
  localparam int FRAC_MSB = 22;
  localparam int EXP_W = 10;
  localparam int SIG_W = 26;
  localparam int SCALE_W = 5;

  // ----------------------------------------------------------------
  // Field values and default results
  // ----------------------------------------------------------------
  localparam logic [7:0] EXP_ALL_ONES = 8'hFF;
  localparam logic [7:0] EXP_ZERO = 8'h00;
  localparam logic [22:0] FRAC_ZERO = 23'h000000;
  localparam logic [22:0] QUIET_MASK = 23'h400000;
  localparam logic [30:0] INF_MAG = 31'h7F800000;
  localparam logic [30:0] ZERO_MAG = 31'h00000000;
  localparam logic [31:0] QNAN_DEFAULT = 32'h7FC00000;
  localparam logic [31:0] NEG_INF = 32'hFF800000;
  localparam logic [31:0] BOUNDS_NAN_RESULT = 32'hC0000000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [31:0] UNS_SAT_POS = 32'hFFFFFFFF;
  localparam logic [31:0] SGN_SAT_POS = 32'h7FFFFFFF;
  localparam logic [31:0] SGN_SAT_NEG = 32'h80000000;

  // ----------------------------------------------------------------
  // Exponent arithmetic
  // ----------------------------------------------------------------
  localparam logic signed [EXP_W:0] EXP_BIAS = 11'sh07F;
  localparam logic signed [EXP_W:0] EXP_MIN_NORMAL = 11'sh001;
  localparam logic signed [EXP_W:0] EXP_INF_BIASED = 11'sh0FF;
  localparam logic signed [EXP_W:0] UNS_LIMIT_EXP = 11'sh020;
  localparam logic signed [EXP_W:0] SGN_LIMIT_EXP = 11'sh01F;
  localparam logic signed [EXP_W:0] ONE_EXP = 11'sh000;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [VEC_W-1:0] VEC_RST = 128'h0;
  localparam logic SAT_RST = 1'b0;
  localparam logic VALID_RST = 1'b0;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUB = 4'h1,
    OP_MUL = 4'h2,
    OP_MADD = 4'h3,
    OP_RECIP = 4'h4,
    OP_RSQRT = 4'h5,
    OP_LOG2 = 4'h6,
    OP_CONV_U = 4'h7,
    OP_CONV_S = 4'h8,
    OP_CMP_BOUNDS = 4'h9,
    OP_CMP_OTHER = 4'hA
  } vfs_op_type;

endpackage

// ### vfs_round_pack.sv
/*
  Packs an unbounded intermediate into single precision.
  Assumes a normalised significand: hidden bit on top, guard and sticky below.
*/
`timescale 1ns/1ps
module vfs_round_pack
(
  input wire logic intermSign,
  input wire logic signed [vfs_pkg::EXP_W-1:0] intermExp,
  input wire logic [vfs_pkg::SIG_W-1:0] intermSig,
  input wire logic intermZero,
  input wire logic intermInf,
  input wire logic flushToZeroMode,
  output logic [vfs_pkg::ELEM_W-1:0] packedResult
);
  import vfs_pkg::*;

  logic signed [EXP_W:0] biasedExp;
  logic [EXP_W:0] shiftAmount;
  logic [SIG_W-1:0] shiftedSig;
  logic lostBits;
  logic roundUp;
  logic tiny;
  logic [30:0] magField;

  // ----------------------------------------------------------------
  // Round to nearest even, denormalising first when tiny
  // ----------------------------------------------------------------
  // Tininess is judged on the exponent before rounding.
  always_comb
  begin
    biasedExp = {intermExp[EXP_W-1], intermExp} + EXP_BIAS;
    tiny = !intermZero && (biasedExp < EXP_MIN_NORMAL);
    shiftAmount = tiny ? (EXP_W + 1)'(EXP_MIN_NORMAL - biasedExp) : '0;
    shiftedSig = intermSig >> shiftAmount;
    lostBits = |(intermSig & ~({SIG_W{1'b1}} << shiftAmount));
    roundUp = shiftedSig[1] && (shiftedSig[0] || lostBits || shiftedSig[2]);
    magField = tiny ? {EXP_ZERO, shiftedSig[24:2]} : {biasedExp[7:0], shiftedSig[24:2]};
    // A carry out of the fraction walks into the exponent, up to infinity.
    magField = magField + 31'(roundUp);
    if (intermZero)
    begin
      packedResult = {intermSign, ZERO_MAG};
    end
    else if (intermInf || biasedExp >= EXP_INF_BIASED)
    begin
      packedResult = {intermSign, INF_MAG};
    end
    else if (tiny && flushToZeroMode)
    begin
      packedResult = {intermSign, ZERO_MAG};
    end
    else
    begin
      packedResult = {intermSign, magField};
    end
  end

endmodule // vfs_round_pack

// ### vfs_special_value_unit.sv
/*
  Special-value substitution for four single-precision lanes.
  Sticky saturation flag.
  Assumes same-clock inputs, core results arriving with their operands.
*/
`timescale 1ns/1ps
module vfs_special_value_unit
(
  input wire logic clk,
  input wire logic rst,
  input wire logic opValid,
  input wire vfs_pkg::vfs_op_type opCode,
  input wire logic flushToZeroMode,
  input wire logic [vfs_pkg::SCALE_W-1:0] scaleImmediate,
  input wire logic [vfs_pkg::VEC_W-1:0] firstSourceOperand,
  input wire logic [vfs_pkg::VEC_W-1:0] secondSourceOperand,
  input wire logic [vfs_pkg::VEC_W-1:0] thirdSourceOperand,
  input wire logic [vfs_pkg::VEC_W-1:0] coreResult,
  input wire logic [vfs_pkg::LANES-1:0] intermSign,
  input wire logic [vfs_pkg::LANES*vfs_pkg::EXP_W-1:0] intermExp,
  input wire logic [vfs_pkg::LANES*vfs_pkg::SIG_W-1:0] intermSig,
  input wire logic [vfs_pkg::LANES-1:0] intermZero,
  input wire logic [vfs_pkg::LANES-1:0] intermInf,
  input wire logic satClear,
  output logic resultValid,
  output logic [vfs_pkg::VEC_W-1:0] resultData,
  output logic [vfs_pkg::VEC_W-1:0] flushedFirst,
  output logic [vfs_pkg::VEC_W-1:0] flushedSecond,
  output logic [vfs_pkg::VEC_W-1:0] flushedThird,
  output logic saturationFlag
);
  import vfs_pkg::*;

  logic [VEC_W-1:0] laneResult;
  logic [LANES-1:0] laneSatHit;
  logic [VEC_W-1:0] flushedFirstComb;
  logic [VEC_W-1:0] flushedSecondComb;
  logic [VEC_W-1:0] flushedThirdComb;
  logic isConvOp;
  logic satSet;
  logic resultValid_reg;
  logic [VEC_W-1:0] resultData_reg;
  logic [VEC_W-1:0] flushedFirst_reg;
  logic [VEC_W-1:0] flushedSecond_reg;
  logic [VEC_W-1:0] flushedThird_reg;
  logic saturationFlag_reg;

  // ----------------------------------------------------------------
  // Per-lane datapath
  // ----------------------------------------------------------------
  // Lanes share no logic, so no lane sees another lane's operands.
  for (genvar lane = 0; lane < LANES; lane++)
  begin : gLane
    logic [ELEM_W-1:0] elemA, elemB, elemC;
    logic [ELEM_W-1:0] quietA, quietB, quietC;
    logic [ELEM_W-1:0] rounded, coreElem, result;
    logic nanA, nanB, nanC;
    logic infA, infB, infC;
    logic zeroA, zeroB, zeroC;
    logic sA, sB, sC;
    logic invalidOp, ovfUns, ovfSgn, satHit;
    logic signed [EXP_W:0] scaledExp;

    vfs_classify uClassA (
      .element(firstSourceOperand[lane*ELEM_W +: ELEM_W]),
      .flushToZeroMode,
      .flushedElement(elemA),
      .quietedElement(quietA),
      .isNan(nanA),
      .isInf(infA),
      .isZero(zeroA)
    );

    vfs_classify uClassB (
      .element(secondSourceOperand[lane*ELEM_W +: ELEM_W]),
      .flushToZeroMode,
      .flushedElement(elemB),
      .quietedElement(quietB),
      .isNan(nanB),
      .isInf(infB),
      .isZero(zeroB)
    );

    vfs_classify uClassC (
      .element(thirdSourceOperand[lane*ELEM_W +: ELEM_W]),
      .flushToZeroMode,
      .flushedElement(elemC),
      .quietedElement(quietC),
      .isNan(nanC),
      .isInf(infC),
      .isZero(zeroC)
    );

    vfs_round_pack uRound (
      .intermSign(intermSign[lane]),
      .intermExp(intermExp[lane*EXP_W +: EXP_W]),
      .intermSig(intermSig[lane*SIG_W +: SIG_W]),
      .intermZero(intermZero[lane]),
      .intermInf(intermInf[lane]),
      .flushToZeroMode,
      .packedResult(rounded)
    );

    assign sA = elemA[SIGN_POS];
    assign sB = elemB[SIGN_POS];
    assign sC = elemC[SIGN_POS];
    assign coreElem = coreResult[lane*ELEM_W +: ELEM_W];

    // Invalid: cancelling infinities, or infinity times zero. Fused is first*third+second.
    always_comb
    begin
      invalidOp = 1'b0;
      case (opCode)
        OP_ADD: invalidOp = infA && infB && (sA != sB);
        OP_SUB: invalidOp = infA && infB && (sA == sB);
        OP_MUL: invalidOp = (infA && zeroB) || (zeroA && infB);
        OP_MADD:
        begin
          invalidOp = (infA && zeroC) || (zeroA && infC) ||
            ((infA || infC) && !zeroA && !zeroC && infB && ((sA ^ sC) != sB));
        end
        default: invalidOp = 1'b0;
      endcase
    end

    // Scaled-exponent range check; zero or denormal sources never overflow.
    always_comb
    begin
      scaledExp = $signed({3'b000, elemA[EXP_MSB:EXP_LSB]}) - EXP_BIAS +
        $signed({6'b000000, scaleImmediate});
      ovfUns = infA || (!zeroA && elemA[EXP_MSB:EXP_LSB] != EXP_ZERO &&
        (sA ? (scaledExp >= ONE_EXP) : (scaledExp >= UNS_LIMIT_EXP)));
      ovfSgn = infA || (elemA[EXP_MSB:EXP_LSB] != EXP_ZERO && (scaledExp > SGN_LIMIT_EXP ||
        (scaledExp == SGN_LIMIT_EXP && (!sA || elemA[FRAC_MSB:0] != FRAC_ZERO))));
    end

    // No path traps; an exception only swaps in a default value.
    always_comb
    begin
      result = coreElem;
      satHit = 1'b0;
      case (opCode)
        OP_ADD, OP_SUB, OP_MUL, OP_MADD:
        begin
          if (nanA)
            result = quietA;
          else if (nanB)
            result = quietB;
          else if (nanC && opCode == OP_MADD)
            result = quietC;
          else if (invalidOp)
            result = QNAN_DEFAULT;
          else
            result = rounded;
        end
        OP_RECIP:
        begin
          if (nanA)
            result = quietA;
          else if (zeroA)
            result = {sA, INF_MAG};
        end
        OP_RSQRT:
        begin
          if (nanA)
            result = quietA;
          else if (zeroA)
            result = {sA, INF_MAG};
          else if (sA)
            result = QNAN_DEFAULT;
        end
        OP_LOG2:
        begin
          if (nanA)
            result = quietA;
          else if (zeroA)
            result = NEG_INF;
          else if (sA)
            result = QNAN_DEFAULT;
        end
        OP_CONV_U:
        begin
          if (nanA)
            result = ZERO_WORD;
          else if (ovfUns)
          begin
            result = sA ? ZERO_WORD : UNS_SAT_POS;
            satHit = 1'b1;
          end
        end
        OP_CONV_S:
        begin
          if (nanA)
            result = ZERO_WORD;
          else if (ovfSgn)
          begin
            result = sA ? SGN_SAT_NEG : SGN_SAT_POS;
            satHit = 1'b1;
          end
        end
        OP_CMP_BOUNDS:
        begin
          if (nanA || nanB)
            result = BOUNDS_NAN_RESULT;
        end
        OP_CMP_OTHER:
        begin
          if (nanA || nanB)
            result = ZERO_WORD;
        end
        default: result = coreElem;
      endcase
    end

    assign laneResult[lane*ELEM_W +: ELEM_W] = result;
    assign laneSatHit[lane] = satHit;
    assign flushedFirstComb[lane*ELEM_W +: ELEM_W] = elemA;
    assign flushedSecondComb[lane*ELEM_W +: ELEM_W] = elemB;
    assign flushedThirdComb[lane*ELEM_W +: ELEM_W] = elemC;
  end

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------
  // Data loads only with a valid operation, so it holds while idle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      resultValid_reg <= VALID_RST;
      resultData_reg <= VEC_RST;
    end
    else
    begin
      resultValid_reg <= opValid;
      if (opValid)
        resultData_reg <= laneResult;
    end
  end

  // ----------------------------------------------------------------
  // Flushed operand register
  // ----------------------------------------------------------------
  // Cores take flushed sources a cycle late, off their critical path.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flushedFirst_reg <= VEC_RST;
      flushedSecond_reg <= VEC_RST;
      flushedThird_reg <= VEC_RST;
    end
    else
    begin
      flushedFirst_reg <= flushedFirstComb;
      flushedSecond_reg <= flushedSecondComb;
      flushedThird_reg <= flushedThirdComb;
    end
  end

  // ----------------------------------------------------------------
  // Sticky saturation flag
  // ----------------------------------------------------------------
  // A saturating lane in the clearing cycle wins, so no event is lost.
  assign isConvOp = (opCode == OP_CONV_U) || (opCode == OP_CONV_S);
  assign satSet = opValid && isConvOp && (|laneSatHit);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      saturationFlag_reg <= SAT_RST;
    else if (satSet)
      saturationFlag_reg <= 1'b1;
    else if (satClear)
      saturationFlag_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign resultValid = resultValid_reg;
  assign resultData = resultData_reg;
  assign flushedFirst = flushedFirst_reg;
  assign flushedSecond = flushedSecond_reg;
  assign flushedThird = flushedThird_reg;
  assign saturationFlag = saturationFlag_reg;

endmodule // vfs_special_value_unit

// ### vfs_special_value_unit_assertions.sv
/*
  Port-level assertions for the unit.
  Assumes one clock and an active-high reset.
*/
`timescale 1ns/1ps
module vfs_check
(
  input wire logic clk,
  input wire logic rst,
  input wire logic opValid,
  input wire vfs_pkg::vfs_op_type opCode,
  input wire logic flushToZeroMode,
  input wire logic [127:0] firstSourceOperand,
  input wire logic satClear,
  input wire logic resultValid,
  input wire logic [127:0] resultData,
  input wire logic [127:0] flushedFirst,
  input wire logic saturationFlag
);
  import vfs_pkg::*;
  logic nanLane0;
  logic convOp;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Lane-0 class and conversion decode, shared by several checks.
  assign nanLane0 = firstSourceOperand[30:23] == EXP_ALL_ONES && firstSourceOperand[22:0] != 0;
  assign convOp = opValid && (opCode == OP_CONV_U || opCode == OP_CONV_S);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence sConvNan;
    convOp && nanLane0;
  endsequence
  sequence sArithNan;
    opValid && opCode inside {OP_ADD, OP_SUB, OP_MUL, OP_MADD} && nanLane0;
  endsequence
  AST_RESULT_PULSE: assert property (opValid |=> resultValid)
    else $error("result valid missing after an operation");
  AST_IDLE_HOLD: assert property (!opValid |=> !resultValid && $stable(resultData))
    else $error("result changed without an operation");
  AST_SAT_STICKY: assert property (saturationFlag && !satClear |=> saturationFlag)
    else $error("saturation dropped without a clear");
  AST_SAT_CAUSE: assert property ($rose(saturationFlag) |-> $past(convOp))
    else $error("saturation rose without a conversion");
  AST_SAT_CLEAR: assert property (satClear && !convOp |=> !saturationFlag)
    else $error("saturation survived a clear");
  AST_CONV_NAN: assert property (sConvNan |=> resultData[31:0] == ZERO_WORD)
    else $error("conversion of NaN not zero");
  AST_BOUNDS_NAN: assert property (opValid && opCode == OP_CMP_BOUNDS && nanLane0
    |=> resultData[31:0] == BOUNDS_NAN_RESULT) else $error("bounds compare of NaN wrong");
  AST_NAN_QUIET: assert property (sArithNan
    |=> resultData[31:0] == ($past(firstSourceOperand[31:0]) | {9'h000, QUIET_MASK}))
    else $error("selected NaN not quieted copy");
  AST_RECIP_ZERO: assert property (opValid && opCode == OP_RECIP
    && firstSourceOperand[30:0] == ZERO_MAG
    |=> resultData[31:0] == {$past(firstSourceOperand[31]), INF_MAG})
    else $error("reciprocal of zero not signed infinity");
  AST_FLUSH_DENORM: assert property (flushToZeroMode && firstSourceOperand[126:119] == 0
    |=> flushedFirst[127:96] == {$past(firstSourceOperand[127]), ZERO_MAG})
    else $error("denormal source not flushed");
endmodule // vfs_check

bind vfs_special_value_unit vfs_check vfs_check_inst (.clk, .rst, .opValid, .opCode,
  .flushToZeroMode, .firstSourceOperand, .satClear, .resultValid, .resultData,
  .flushedFirst, .saturationFlag);
